/* rtl/cfgload_params.svh */
// Shared constants for the parallel configuration loader: times, counts, register map.
// Assumes a 20 MHz system clock on both ends; times convert to cycles of that clock.
`ifndef CFGLOAD_PARAMS_SVH
`define CFGLOAD_PARAMS_SVH
`define SYS_PERIOD_NS      50
`define T_CFG_MIN_NS       2000
`define CFG_CYC            ((`T_CFG_MIN_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define T_CF2CD_MAX_NS     600
`define CF2CD_CYC          (`T_CF2CD_MAX_NS / `SYS_PERIOD_NS)
`define T_STATUS_MIN_US    268
`define STATUS_MIN_CYC     ((`T_STATUS_MIN_US * 1000 + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define T_CF2ST1_MAX_US    1506
`define T_CF2CK_MIN_US     1506
`define CF2CK_CYC          ((`T_CF2CK_MIN_US * 1000 + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define T_ST2CK_MIN_NS     2000
`define ST2CK_CYC          ((`T_ST2CK_MIN_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define F_CCLK_MAX_MHZ     125
`define CCLK_HALF_CYC      2
`define T_CD2UM_MIN_US     175
`define CD2UM_CYC          ((`T_CD2UM_MIN_US * 1000 + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define T_INIT_CYC         17408
`define T_POR_FAST_MIN_MS  4
`define POR_FAST_CYC       ((`T_POR_FAST_MIN_MS * 1000000) / `SYS_PERIOD_NS)
`define T_POR_STD_MIN_MS   100
`define POR_STD_CYC        ((`T_POR_STD_MIN_MS * 1000000) / `SYS_PERIOD_NS)
`define T_TCK_MIN_NS       30
`define T_TCK_LOWBAT_NS    167
`define UCLK_WAIT_CYC      (4 * 2 * `CCLK_HALF_CYC)
`define REG_CTRL           2'h0
`define REG_LEN            2'h1
`define REG_DATA           2'h2
`define REG_STAT           2'h3
`define CTRL_START         0
`define CTRL_WIDE          1
`define CTRL_ENC           2
`define CTRL_COMP          3
`define CTRL_MON           4
`define CTRL_UCLK          5
`define STAT_BUSY          0
`define STAT_DONE          1
`define STAT_ERR           2
`define STAT_UMODE         3
`define STAT_FULL          4
`define CTRL_RESET         6'h00
`define LEN_RESET          16'h0001
`endif

/* rtl/cfgload_pkg.sv */
// Types shared by both ends of the configuration link.
// Assumes cfgload_params.svh is on the include path.
package cfgload_pkg;
	typedef enum logic [2:0] {
		D_POR  = 3'b000,
		D_RST  = 3'b001,
		D_LOAD = 3'b010,
		D_TAIL = 3'b011,
		D_INIT = 3'b100,
		D_USER = 3'b101
	} dev_state_e;
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_RST   = 3'b001,
		H_WAIT  = 3'b010,
		H_LOAD  = 3'b011,
		H_TAIL  = 3'b100,
		H_DONE  = 3'b101,
		H_UWAIT = 3'b110,
		H_UCLK  = 3'b111
	} host_state_e;
	// Clock-to-word ratio for bus width and the two stream options.
	function automatic logic [2:0] ratio_f(input logic wide, input logic enc, input logic comp);
		if (!wide)
			ratio_f = comp ? 3'h2 : 3'h1;
		else if (comp)
			ratio_f = 3'h4;
		else
			ratio_f = enc ? 3'h2 : 3'h1;
	endfunction
endpackage

/* rtl/cfgload_if.sv */
// Link between the configuration host and the loaded device.
// The status line is open drain; its level is resolved here from both enables.
`timescale 1ns/100ps
interface cfgload_if;
	logic        config_clock;
	logic [15:0] config_data;
	logic        restart_n;
	logic        host_status_oe_n;
	logic        dev_status_oe_n;
	logic        status_n;
	logic        done;
	logic        user_init_clock;
	logic        init_done;
	// Either party pulling low wins; the pull-up is implied.
	assign status_n = host_status_oe_n & dev_status_oe_n;
	modport dev (input config_clock, config_data, restart_n, user_init_clock, status_n,
		output dev_status_oe_n, done, init_done);
	modport host (output config_clock, config_data, restart_n, user_init_clock,
		host_status_oe_n, input status_n, done, init_done);
endinterface

/* rtl/cfgload_device.sv */
// Device end: power-on delay, restart handling, word capture, initialization.
// Assumes the link pins are asynchronous to CLK_SYS_I and are synchronised here.
`timescale 1ns/100ps
`include "cfgload_params.svh"
module cfgload_device import cfgload_pkg::*; #(
	parameter int STATUS_MIN_CYC = `STATUS_MIN_CYC,
	parameter int POR_FAST_CYC   = `POR_FAST_CYC,
	parameter int POR_STD_CYC    = `POR_STD_CYC
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic        CE_I,
	cfgload_if.dev           LINK,
	input  wire logic        SCHEME_SELECT_I,
	input  wire logic        WIDE_I,
	input  wire logic        ENCRYPT_I,
	input  wire logic        COMPRESS_I,
	input  wire logic        USER_CLK_OPT_I,
	input  wire logic [15:0] LOAD_WORDS_I,
	output logic      [15:0] WORD_O,
	output logic             WORD_VALID_O,
	output logic             USER_MODE_O
);
	logic [18:0] sync1_reg;
	logic [18:0] sync2_reg;
	logic        cclk_prev_reg;
	logic        uclk_prev_reg;
	dev_state_e  state_reg;
	dev_state_e  state_next;
	logic [23:0] cnt_reg;
	logic [23:0] cnt_next;
	logic [2:0]  edge_reg;
	logic [2:0]  edge_next;
	logic [15:0] words_reg;
	logic [15:0] words_next;
	logic        cclk_rise;
	logic        uclk_rise;
	logic        restart_n_s;
	logic [2:0]  ratio;
	logic [23:0] por_len;

	// Two stages on every link input except the unused status line, so clock edges and data keep equal delay.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sync1_reg <= 19'h00000;
			sync2_reg <= 19'h00000;
		end else if (CE_I) begin
			sync1_reg <= {LINK.config_data, LINK.user_init_clock, LINK.restart_n,
				LINK.config_clock};
			sync2_reg <= sync1_reg;
		end
	end

	// Edge finders look only at the second stage.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cclk_prev_reg <= 1'b0;
			uclk_prev_reg <= 1'b0;
		end else if (CE_I) begin
			cclk_prev_reg <= sync2_reg[0];
			uclk_prev_reg <= sync2_reg[2];
		end
	end

	assign cclk_rise   = sync2_reg[0] & ~cclk_prev_reg;
	assign uclk_rise   = sync2_reg[2] & ~uclk_prev_reg;
	assign restart_n_s = sync2_reg[1];
	assign ratio       = ratio_f(WIDE_I, ENCRYPT_I, COMPRESS_I);
	assign por_len     = SCHEME_SELECT_I ? 24'(POR_FAST_CYC) : 24'(POR_STD_CYC);

	// Next-state logic; a low restart overrides everything after power-on.
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		edge_next  = edge_reg;
		words_next = words_reg;
		case (state_reg)
			D_POR: begin
				cnt_next = cnt_reg + 24'h000001;
				if (cnt_reg >= por_len - 24'h000001) begin
					state_next = D_RST;
					cnt_next   = 24'h000000;
				end
			end
			D_RST: begin
				// Status stays low the least time, then follows restart high.
				if (cnt_reg < 24'(STATUS_MIN_CYC))
					cnt_next = cnt_reg + 24'h000001;
				else if (restart_n_s) begin
					state_next = D_LOAD;
					edge_next  = 3'h0;
					words_next = 16'h0000;
				end
			end
			D_LOAD: begin
				if (cclk_rise) begin
					edge_next = edge_reg + 3'h1;
					if (edge_reg == ratio - 3'h1) begin
						edge_next  = 3'h0;
						words_next = words_reg + 16'h0001;
						if (words_reg == LOAD_WORDS_I - 16'h0001) begin
							state_next = (ratio == 3'h1) ? D_INIT : D_TAIL;
							cnt_next   = 24'h000000;
						end
					end
				end
			end
			D_TAIL: begin
				// The last word still needs ratio-1 edges to be unpacked.
				if (cclk_rise) begin
					edge_next = edge_reg + 3'h1;
					if (edge_reg == ratio - 3'h2)
						state_next = D_INIT;
				end
			end
			D_INIT: begin
				if (USER_CLK_OPT_I) begin
					if (uclk_rise)
						cnt_next = cnt_reg + 24'h000001;
					if (cnt_reg >= 24'(`T_INIT_CYC))
						state_next = D_USER;
				end else begin
					cnt_next = cnt_reg + 24'h000001;
					if (cnt_reg >= 24'(`CD2UM_CYC - 1))
						state_next = D_USER;
				end
			end
			D_USER: begin
				state_next = D_USER;
			end
			default: begin
				state_next = D_POR;
			end
		endcase
		if (!restart_n_s && state_reg != D_POR && state_reg != D_RST) begin
			state_next = D_RST;
			cnt_next   = 24'h000000;
		end
	end

	// Sequencer registers.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_reg <= D_POR;
			cnt_reg   <= 24'h000000;
			edge_reg  <= 3'h0;
			words_reg <= 16'h0000;
		end else if (CE_I) begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			edge_reg  <= edge_next;
			words_reg <= words_next;
		end
	end

	// Pin outputs are registered from the next state, which keeps restart-to-low
	// at three system cycles, well inside the allowed bound.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			LINK.dev_status_oe_n <= 1'b0;
			LINK.done            <= 1'b0;
			LINK.init_done       <= 1'b0;
			USER_MODE_O          <= 1'b0;
		end else if (CE_I) begin
			LINK.dev_status_oe_n <= !(state_next == D_POR || state_next == D_RST);
			LINK.done            <= (state_next == D_INIT || state_next == D_USER);
			LINK.init_done       <= (state_next == D_USER);
			USER_MODE_O          <= (state_next == D_USER);
		end
	end

	// A word is taken on the first rising edge of its slot.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			WORD_O       <= 16'h0000;
			WORD_VALID_O <= 1'b0;
		end else if (CE_I) begin
			WORD_VALID_O <= 1'b0;
			if (state_reg == D_LOAD && state_next != D_RST && cclk_rise && edge_reg == 3'h0) begin
				WORD_O       <= WIDE_I ? sync2_reg[18:3] : {8'h00, sync2_reg[10:3]};
				WORD_VALID_O <= 1'b1;
			end
		end
	end
endmodule

/* rtl/cfgload_host.sv */
// Host end: AHB-Lite register slave that drives the configuration link.
// Assumes one AHB-Lite master on the same clock; link inputs are asynchronous.
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`include "cfgload_params.svh"
module cfgload_host import cfgload_pkg::*; #(
	parameter int CF2CK_CYC = `CF2CK_CYC
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic        CE_I,
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	cfgload_if.host          LINK
);
	logic [2:0]  sync1_reg;
	logic [2:0]  sync2_reg;
	logic        dph_wr_reg;
	logic [1:0]  dph_addr_reg;
	logic [5:0]  ctrl_reg;
	logic [15:0] len_reg;
	logic [15:0] buf_reg;
	logic        full_reg;
	logic        err_reg;
	host_state_e state_reg;
	logic [23:0] cnt_reg;
	logic [1:0]  div_reg;
	logic [2:0]  edge_reg;
	logic        wl_reg;
	logic [15:0] words_reg;
	logic        aph;
	logic        wr_done;
	logic        start;
	logic        tick;
	logic        take;
	logic        status_n_s;
	logic        done_s;
	logic        init_s;
	logic        fault;
	logic [2:0]  ratio;

	// Status, done and init-done come from the far end: two stages each.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else if (CE_I) begin
			sync1_reg <= {LINK.init_done, LINK.done, LINK.status_n};
			sync2_reg <= sync1_reg;
		end
	end

	assign status_n_s = sync2_reg[0];
	assign done_s     = sync2_reg[1];
	assign init_s     = sync2_reg[2];
	assign ratio      = ratio_f(ctrl_reg[`CTRL_WIDE], ctrl_reg[`CTRL_ENC], ctrl_reg[`CTRL_COMP]);

	// Bus decode. Only a data write to a full word buffer waits.
	assign aph         = HSEL_I & HREADY_I & HTRANS_I[1];
	assign HREADYOUT_O = !(dph_wr_reg && dph_addr_reg == `REG_DATA && full_reg);
	assign HRESP_O     = 1'b0;
	assign wr_done     = dph_wr_reg & HREADYOUT_O;
	assign start       = wr_done && dph_addr_reg == `REG_CTRL && HWDATA_I[`CTRL_START];

	// Address phase capture and read data, which is ready one cycle later.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			dph_wr_reg   <= 1'b0;
			dph_addr_reg <= 2'h0;
			HRDATA_O     <= 32'h00000000;
		end else if (CE_I && HREADYOUT_O) begin
			dph_wr_reg   <= aph & HWRITE_I;
			dph_addr_reg <= HADDR_I[3:2];
			if (aph && !HWRITE_I) begin
				case (HADDR_I[3:2])
					`REG_CTRL: HRDATA_O <= {26'h0000000, ctrl_reg};
					`REG_LEN:  HRDATA_O <= {16'h0000, len_reg};
					`REG_DATA: HRDATA_O <= {16'h0000, buf_reg};
					default:   HRDATA_O <= {21'h000000, state_reg, 3'h0, full_reg,
						init_s, err_reg, done_s, state_reg != H_IDLE};
				endcase
			end else begin
				HRDATA_O <= 32'h00000000;
			end
		end
	end

	// Option and length registers; options only change while idle.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_reg <= `CTRL_RESET;
			len_reg  <= `LEN_RESET;
		end else if (CE_I && wr_done && state_reg == H_IDLE) begin
			if (dph_addr_reg == `REG_CTRL)
				ctrl_reg <= {HWDATA_I[5:1], 1'b0};
			if (dph_addr_reg == `REG_LEN)
				len_reg <= HWDATA_I[15:0];
		end
	end

	// One-word buffer; the engine draining it gives back-pressure to the bus.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			buf_reg  <= 16'h0000;
			full_reg <= 1'b0;
		end else if (CE_I) begin
			if (wr_done && dph_addr_reg == `REG_DATA) begin
				buf_reg  <= HWDATA_I[15:0];
				full_reg <= 1'b1;
			end else if (take) begin
				full_reg <= 1'b0;
			end
		end
	end

	// Error flag: set by status low during loading, cleared by writing one.
	// A new fault in the clearing cycle wins.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			err_reg <= 1'b0;
		else if (CE_I) begin
			if (fault)
				err_reg <= 1'b1;
			else if (wr_done && dph_addr_reg == `REG_STAT && HWDATA_I[`STAT_ERR])
				err_reg <= 1'b0;
		end
	end

	// Half-period divider for both link clocks. Two system cycles per half gives
	// 200 ns, far slower than the fastest allowed and slow enough to sample.
	// That period also stays above the slowest scan-clock limit, so one divider serves all.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			div_reg <= 2'h0;
		else if (CE_I)
			div_reg <= tick ? 2'h0 : div_reg + 2'h1;
	end

	assign tick  = (div_reg == 2'(`CCLK_HALF_CYC - 1));
	assign take  = CE_I && state_reg == H_LOAD && tick && !LINK.config_clock && !wl_reg
		&& full_reg && !fault;
	assign fault = (state_reg == H_LOAD || state_reg == H_TAIL) && !status_n_s;

	// Link sequencer: restart pulse, start wait, word slots, tail, user clock.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_reg            <= H_IDLE;
			cnt_reg              <= 24'h000000;
			edge_reg             <= 3'h0;
			wl_reg               <= 1'b0;
			words_reg            <= 16'h0000;
			LINK.restart_n       <= 1'b1;
			LINK.config_clock    <= 1'b0;
			LINK.config_data     <= 16'h0000;
			LINK.user_init_clock <= 1'b0;
		end else if (CE_I) begin
			case (state_reg)
				H_IDLE: begin
					if (start) begin
						state_reg      <= H_RST;
						cnt_reg        <= 24'h000000;
						LINK.restart_n <= 1'b0;
					end
				end
				H_RST: begin
					cnt_reg <= cnt_reg + 24'h000001;
					if (cnt_reg >= 24'(`CFG_CYC - 1)) begin
						state_reg      <= H_WAIT;
						cnt_reg        <= 24'h000000;
						LINK.restart_n <= 1'b1;
					end
				end
				H_WAIT: begin
					// Monitored status restarts the count while it is low.
					cnt_reg <= cnt_reg + 24'h000001;
					if (ctrl_reg[`CTRL_MON] && !status_n_s)
						cnt_reg <= 24'h000000;
					else if (ctrl_reg[`CTRL_MON] ? cnt_reg >= 24'(`ST2CK_CYC - 1)
						: cnt_reg >= 24'(CF2CK_CYC - 1)) begin
						state_reg <= H_LOAD;
						edge_reg  <= 3'h0;
						wl_reg    <= 1'b0;
						words_reg <= 16'h0000;
					end
				end
				H_LOAD: begin
					if (fault) begin
						state_reg         <= H_RST;
						cnt_reg           <= 24'h000000;
						LINK.restart_n    <= 1'b0;
						LINK.config_clock <= 1'b0;
					end else if (tick && !LINK.config_clock) begin
						// Data changes a half period before the rising edge.
						if (take) begin
							LINK.config_data <= buf_reg;
							wl_reg           <= 1'b1;
						end else if (wl_reg)
							LINK.config_clock <= 1'b1;
					end else if (tick) begin
						LINK.config_clock <= 1'b0;
						edge_reg          <= edge_reg + 3'h1;
						if (edge_reg == ratio - 3'h1) begin
							edge_reg  <= 3'h0;
							wl_reg    <= 1'b0;
							words_reg <= words_reg + 16'h0001;
							if (words_reg == len_reg - 16'h0001)
								state_reg <= (ratio == 3'h1) ? H_DONE : H_TAIL;
						end
					end
				end
				H_TAIL: begin
					if (fault) begin
						state_reg         <= H_RST;
						cnt_reg           <= 24'h000000;
						LINK.restart_n    <= 1'b0;
						LINK.config_clock <= 1'b0;
					end else if (tick && !LINK.config_clock)
						LINK.config_clock <= 1'b1;
					else if (tick) begin
						LINK.config_clock <= 1'b0;
						edge_reg          <= edge_reg + 3'h1;
						if (edge_reg == ratio - 3'h2)
							state_reg <= H_DONE;
					end
				end
				H_DONE: begin
					cnt_reg <= 24'h000000;
					if (done_s)
						state_reg <= ctrl_reg[`CTRL_UCLK] ? H_UWAIT : H_IDLE;
				end
				H_UWAIT: begin
					cnt_reg <= cnt_reg + 24'h000001;
					if (cnt_reg >= 24'(`UCLK_WAIT_CYC - 1))
						state_reg <= H_UCLK;
				end
				H_UCLK: begin
					// Keeps clocking until the device reports it has finished.
					if (init_s && !LINK.user_init_clock)
						state_reg <= H_IDLE;
					else if (tick)
						LINK.user_init_clock <= !LINK.user_init_clock;
				end
				default: begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	// The host never pulls status low itself.
	assign LINK.host_status_oe_n = 1'b1;
endmodule

/* tb/cfgload_checker.sv */
// Concurrent checks on the configuration link between the host and the device ends.
// Assumes it sits beside the link interface and samples every pin on the system clock.
`timescale 1ns/100ps
module cfgload_checker #(
	parameter int STATUS_MIN_CYC = 20,
	parameter int CF2CK_CYC      = 50
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic        config_clock,
	input  wire logic [15:0] config_data,
	input  wire logic        restart_n,
	input  wire logic        dev_status_oe_n,
	input  wire logic        status_n,
	input  wire logic        done,
	input  wire logic        user_init_clock,
	input  wire logic        init_done
);
	localparam int T_2US    = 40;
	localparam int T_600NS  = 12;
	localparam int T_175US  = 3500;
	localparam int T_437US  = 8740;
	localparam int T_1506US = 30120;
	localparam int T_INIT   = 17408;
	int   low_cnt, st_cnt, rs_cnt, dl_cnt, dn_cnt, uk_cnt;
	logic armed;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	// Cycle counters measured from the link events that the timing limits start at.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			low_cnt <= 0;
			st_cnt  <= 0;
			rs_cnt  <= 0;
			dl_cnt  <= 0;
			dn_cnt  <= 0;
			uk_cnt  <= 0;
			armed   <= 1'b1;
		end else begin
			low_cnt <= restart_n ? 0 : low_cnt + 1;
			st_cnt  <= status_n ? st_cnt + 1 : 0;
			rs_cnt  <= restart_n ? rs_cnt + 1 : 0;
			dl_cnt  <= dev_status_oe_n ? 0 : dl_cnt + 1;
			dn_cnt  <= done ? dn_cnt + 1 : 0;
			uk_cnt  <= !done ? 0 : uk_cnt + ($rose(user_init_clock) ? 1 : 0);
			armed   <= !status_n ? 1'b1 : (config_clock ? 1'b0 : armed);
		end
	end
	// A restart is a falling edge that must pull both done and status low in time.
	sequence s_restart;
		$fell(restart_n);
	endsequence
	sequence s_cleared;
		##[1:T_600NS] (!done && !status_n);
	endsequence
	restart_clear_a: assert property (s_restart |-> s_cleared)
		else $error("done or status not low after restart");
	restart_width_a: assert property ($rose(restart_n) |-> low_cnt >= T_2US)
		else $error("restart pulse too short");
	status_width_a: assert property ($rose(dev_status_oe_n) |-> dl_cnt >= STATUS_MIN_CYC && dl_cnt <= T_1506US)
		else $error("status low pulse out of range");
	status_release_a: assert property (restart_n && !status_n |-> rs_cnt <= T_1506US)
		else $error("status not released in time");
	first_edge_a: assert property ($rose(config_clock) && armed |-> st_cnt >= T_2US || rs_cnt >= CF2CK_CYC)
		else $error("first link clock edge too early");
	data_hold_a: assert property (config_clock |-> $stable(config_data))
		else $error("data moved around link clock high");
	clock_phase_a: assert property ($changed(config_clock) |=> $stable(config_clock))
		else $error("link clock phase too short");
	user_wait_a: assert property ($rose(done) |-> (!user_init_clock) [*8])
		else $error("user clock started too soon after done");
	osc_init_a: assert property ($rose(init_done) && uk_cnt == 0 |-> dn_cnt >= T_175US && dn_cnt <= T_437US)
		else $error("internal init time out of range");
	user_init_a: assert property ($rose(init_done) && uk_cnt != 0 |-> uk_cnt >= T_INIT)
		else $error("user mode before enough user clocks");
endmodule

/* tb/parallel_passive_config_loader_bench.sv */
// Self-checking bench: an AHB-Lite master orders loads, the device end receives them.
// Assumes shortened delay parameters; both ends and the bench share the 20 MHz clock.
`timescale 1ns/100ps
module parallel_passive_config_loader_bench;
	logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sel_fast = 1'b1, ce_q = 1'b1;
	logic        hsel = 1'b0, hwrite = 1'b0, hresp, wvalid, umode;
	logic        wide = 1'b0, enc = 1'b0, comp = 1'b0, uopt = 1'b0, cprev = 1'b0, dprev = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [15:0] nwords = 16'h0001, word;
	wire         hready;
	logic [15:0] got[$];
	int          err_total = 0, compares = 0, cycles = 0, edges = 0, at_done = 0;
	cfgload_if link ();
	cfgload_host #(.CF2CK_CYC(50)) i_cfgload_host (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce),
		.HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
		.HRESP_O(hresp), .LINK(link.host));
	cfgload_device #(.STATUS_MIN_CYC(20), .POR_FAST_CYC(30), .POR_STD_CYC(100)) i_cfgload_device (
		.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .LINK(link.dev), .SCHEME_SELECT_I(sel_fast),
		.WIDE_I(wide), .ENCRYPT_I(enc), .COMPRESS_I(comp), .USER_CLK_OPT_I(uopt),
		.LOAD_WORDS_I(nwords), .WORD_O(word), .WORD_VALID_O(wvalid), .USER_MODE_O(umode));
	cfgload_checker #(.STATUS_MIN_CYC(20), .CF2CK_CYC(50)) i_cfgload_checker (.CLK_SYS_I(clk),
		.RST_N_I(rst_n), .config_clock(link.config_clock), .config_data(link.config_data),
		.restart_n(link.restart_n), .dev_status_oe_n(link.dev_status_oe_n),
		.status_n(link.status_n), .done(link.done), .user_init_clock(link.user_init_clock),
		.init_done(link.init_done));
	// Free-running system clock.
	always #25 clk = ~clk;
	// Captures words, rising link clock edges and the word count at done, and cuts a hang.
	always @(posedge clk) begin
		cycles++;
		// A valid held through a frozen stretch is still one word, so only count it
		// when the edge before this one ran with the enable high.
		if (wvalid === 1'b1 && ce_q === 1'b1)
			got.push_back(word);
		if (link.config_clock === 1'b1 && cprev !== 1'b1)
			edges++;
		if (link.done === 1'b1 && dprev !== 1'b1)
			at_done = got.size();
		cprev = link.config_clock;
		dprev = link.done;
		ce_q = ce;
		if (cycles == 99000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Ready is sampled at the rising edge; read data is taken at the edge that ends the phase.
	task automatic rdy(output logic [31:0] d);
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		d = hrdata;
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		rdy(rd);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy(rd);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(what, exp, x);
	endtask
	// Options are {user clock, monitor, compress, encrypt, wide}; r is the ratio, n the length.
	task automatic load(input logic [4:0] opt, input int r, input int n);
		logic [31:0] s, m;
		int          k, e;
		m = opt[0] ? 32'hFFFF : 32'hFF;
		wide <= opt[0];
		enc <= opt[1];
		comp <= opt[2];
		uopt <= opt[4];
		nwords <= 16'(n);
		wr(32'h4, 32'(n));
		got.delete();
		edges = 0;
		at_done = -1;
		wr(32'h0, {26'h0, opt, 1'b1});
		wr(32'h0, 32'h0);
		for (k = 0; k < n; k++)
			wr(32'h8, 32'hA5C3 + k * 32'h1111);
		// Freeze both ends in mid-stream: the link must not move while the enable is low.
		ce <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		e = edges;
		repeat (20) @(negedge clk);
		chk("frozen edges", e, edges);
		@(posedge clk);
		ce <= 1'b1;
		s = 32'h0;
		while (s[3] !== 1'b1 || s[0] !== 1'b0)
			bus(1'b0, 32'hC, 32'h0, s);
		chk("status", 32'hA, s);
		chk("user mode", 32'h1, {31'h0, umode});
		bus(1'b0, 32'h0, 32'h0, s);
		chk("ctrl kept", {26'h0, opt, 1'b0}, s & 32'h3E);
		chk("word count", n, got.size());
		for (k = 0; k < got.size(); k++)
			chk("word", (32'hA5C3 + k * 32'h1111) & m, {16'h0, got[k]} & m);
		chk("words at done", n, at_done);
		chk("link edges", n * r + r - 1, edges);
	endtask
	// Reset with the fast power-on delay, register reset values, loads over the width and
	// option codes, then a second reset with the standard delay, which must hold status longer.
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (70) @(posedge clk);
		chk("fast power-on", 32'h1, {31'h0, link.status_n});
		rd_chk("ctrl reset", 32'h0, 32'h0);
		rd_chk("len reset", 32'h4, 32'h1);
		rd_chk("stat reset", 32'hC, 32'h0);
		load(5'b01000, 1, 3);
		load(5'b01010, 1, 2);
		load(5'b00100, 2, 3);
		load(5'b01001, 1, 4);
		load(5'b01011, 2, 3);
		load(5'b11111, 4, 3);
		sel_fast <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (70) @(posedge clk);
		chk("slow power-on", 32'h0, {31'h0, link.status_n});
		repeat (70) @(posedge clk);
		chk("slow power-on end", 32'h1, {31'h0, link.status_n});
		chk("user mode cleared", 32'h0, {31'h0, umode});
		rd_chk("stat after reset", 32'hC, 32'h0);
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
endmodule
